//--- core/mbc_core.sv
`timescale 1ns/100ps
module mbc_core #(
  parameter int REF_PERIOD = mbc_pkg::REF_MIN_CYC
) (
  input  wire logic              clock,
  input  wire logic              reset,
  input  wire logic              enable,
  input  wire mbc_pkg::mbc_req_s req,
  input  wire logic              req_valid,
  input  wire logic              sram_mode,
  input  wire logic              hold_ack,
  input  wire logic [7:0]        wdata_lo,
  input  wire logic [7:0]        wdata_hi,
  output logic                   done,
  output logic                   boot_rom_sel_n,
  output logic                   mux_addr_bit9,
  output logic                   mux_addr_bit8,
  output logic                   mux_addr7_or_low_sram_sel_n,
  output logic                   mux_addr6_or_sram_wr_lo_n,
  output logic                   mux_addr5_or_sram_wr_hi_n,
  output logic                   mux_addr4_or_sram_seg9_sel_n,
  output logic                   mux_addr3_or_sram_seg8_sel_n,
  output logic [2:0]             mux_addr_low,
  output logic [3:0]             bank_row_strobe_n,
  output logic                   col_strobe_n,
  output logic                   dram_write_n,
  output logic                   refresh_active,
  output logic                   cpu_xfer_active,
  output logic                   cpu_xfer_active_oe_n,
  output logic                   io_xcvr_enable,
  output logic                   io_xcvr_inward,
  output logic                   cpu_buf_enable_n,
  output logic                   cpu_buf_inward,
  output logic                   parity_low_byte,
  output logic                   parity_high_byte
);
  import mbc_pkg::*;

  mbc_state_e  state_reg, state_next;
  mbc_req_s    req_reg, req_next;
  logic [17:0] ref_cnt_reg, ref_cnt_next;
  logic        ref_due_reg, ref_due_next;
  logic [2:0]  phase_reg, phase_next;
  logic [9:0]  maddr;
  logic [1:0]  bank;
  logic        busy;
  logic        ref_take;
  logic        col_phase;
  logic        rom_hit;
  logic        low_hit;
  logic        seg9_hit;
  logic        seg8_hit;
  logic        wr_lo_hit;
  logic        wr_hi_hit;

  // Access sequencer; a due refresh wins over a new request so rows never starve
  always_comb begin
    state_next = state_reg;
    req_next   = req_reg;
    phase_next = phase_reg;
    ref_take   = 1'b0;
    done       = 1'b0;
    case (state_reg)
      MBC_IDLE: begin
        phase_next = 3'h0;
        if (ref_due_reg) begin
          state_next = MBC_REF;
          ref_take   = 1'b1; // Tells the refresh timer its request is served
        end else if (req_valid && req.mem) begin
          // The request is copied, so the bus side may move on after the take
          req_next   = req;
          state_next = MBC_ROW;
        end
      end
      MBC_ROW: begin
        phase_next = phase_reg + 3'h1;
        if (phase_reg == 3'(ROW_COL_GAP - 1)) begin
          phase_next = 3'h0;
          state_next = MBC_COL;
        end
      end
      MBC_COL: begin
        phase_next = phase_reg + 3'h1;
        if (phase_reg == 3'(CAS_LEN - 1)) begin
          phase_next = 3'h0;
          state_next = MBC_DONE;
        end
      end
      MBC_DONE: begin
        done       = 1'b1;
        state_next = MBC_IDLE;
      end
      MBC_REF: begin
        phase_next = phase_reg + 3'h1;
        if (phase_reg == 3'(REF_PULSE - 1)) state_next = MBC_IDLE;
      end
      default: state_next = MBC_IDLE;
    endcase
  end

  // Sequencer registers; the clock enable freezes everything
  always_ff @(posedge clock) begin
    if (reset) begin
      state_reg <= MBC_IDLE;
      req_reg   <= '0;
      phase_reg <= 3'h0;
    end else if (enable) begin
      state_reg <= state_next;
      req_reg   <= req_next;
      phase_reg <= phase_next;
    end
  end

  // Refresh timer runs regardless of traffic; a wrap in the same cycle as the
  // sequencer's take keeps the request pending, so no refresh is ever lost
  always_comb begin
    ref_cnt_next = ref_cnt_reg + 18'h00001;
    ref_due_next = ref_due_reg;
    if (ref_take) begin
      ref_due_next = 1'b0;
    end
    if (ref_cnt_reg >= 18'(REF_PERIOD - 1)) begin
      ref_cnt_next = 18'h00000; // Counts zero up to REF_PERIOD - 1
      ref_due_next = 1'b1; // RL10
    end
  end

  // Refresh timer registers, frozen with the rest by the clock enable
  always_ff @(posedge clock) begin
    if (reset) begin
      ref_cnt_reg <= 18'h00000;
      ref_due_reg <= 1'b0;
    end else if (enable) begin
      ref_cnt_reg <= ref_cnt_next;
      ref_due_reg <= ref_due_next;
    end
  end

  // Row phase carries A19..A10, column phase A9..A0
  assign busy      = (state_reg == MBC_ROW) || (state_reg == MBC_COL);
  assign col_phase = (state_reg == MBC_COL);
  assign maddr     = (state_reg == MBC_ROW) ? req_reg.addr[19:10] : req_reg.addr[9:0]; // RL3
  assign bank      = req_reg.addr[19:18];

  // Address window decodes, only while an access is in flight
  assign rom_hit  = req_reg.mem && busy && (req_reg.addr[19:16] == ROM_SEG); // RL1
  assign low_hit  = busy && (req_reg.addr[19] == 1'b0); // RL4
  assign seg9_hit = busy && (req_reg.addr[19:16] == SRAM_SEG9); // RL6
  assign seg8_hit = busy && (req_reg.addr[19:16] == SRAM_SEG8); // RL6

  // Byte write strobes wait for the column phase so selects settle first
  assign wr_lo_hit = col_phase && req_reg.write && req_reg.byte_lo; // RL5
  assign wr_hi_hit = col_phase && req_reg.write && req_reg.byte_hi; // RL5

  // DRAM strobes; refresh is row-only and opens every bank at once
  always_comb begin
    bank_row_strobe_n = 4'hF;
    col_strobe_n      = 1'b1;
    dram_write_n      = 1'b1;
    if (state_reg == MBC_REF) begin
      bank_row_strobe_n = 4'h0; // RL10
    end else if (!sram_mode && busy) begin
      // Byte lanes sit in paired banks; the lane picks the strobe
      bank_row_strobe_n[{bank[0], 1'b0}] = ~req_reg.byte_lo; // RL7
      bank_row_strobe_n[{bank[0], 1'b1}] = ~req_reg.byte_hi; // RL7
      col_strobe_n = ~col_phase; // RL8
      dram_write_n = ~req_reg.write; // RL9
    end
  end

  // Boot ROM select and the address pins that never change meaning
  always_comb begin
    boot_rom_sel_n = ~rom_hit; // RL1
    mux_addr_bit9  = maddr[9]; // RL3
    mux_addr_bit8  = maddr[8]; // RL3
    mux_addr_low   = maddr[2:0]; // RL3
  end

  // Five shared pins; the mode bit is static, so switching mid-access is not handled
  always_comb begin
    if (sram_mode) begin // RL2
      mux_addr7_or_low_sram_sel_n  = ~low_hit; // RL4
      mux_addr6_or_sram_wr_lo_n    = ~wr_lo_hit; // RL5
      mux_addr5_or_sram_wr_hi_n    = ~wr_hi_hit; // RL5
      mux_addr4_or_sram_seg9_sel_n = ~seg9_hit; // RL6
      mux_addr3_or_sram_seg8_sel_n = ~seg8_hit; // RL6
    end else begin
      mux_addr7_or_low_sram_sel_n  = maddr[7]; // RL3
      mux_addr6_or_sram_wr_lo_n    = maddr[6]; // RL3
      mux_addr5_or_sram_wr_hi_n    = maddr[5]; // RL3
      mux_addr4_or_sram_seg9_sel_n = maddr[4]; // RL3
      mux_addr3_or_sram_seg8_sel_n = maddr[3]; // RL3
    end
  end

  // Refresh flag follows the sequencer state, so it covers the whole row pulse
  assign refresh_active = (state_reg == MBC_REF); // RL10

  // Bus buffer steering; data enable floats in hold acknowledge
  assign cpu_xfer_active      = req_valid && (req.mem || req.io || req.inta); // RL16
  assign cpu_xfer_active_oe_n = hold_ack; // RL16
  assign cpu_buf_enable_n     = ~(cpu_xfer_active && !req.dma && !req.t2 && !hold_ack); // RL13 RL14
  assign cpu_buf_inward       = req.write; // RL15
  assign io_xcvr_enable       = req_valid && (req.io || req.dma); // RL11
  assign io_xcvr_inward       = req_valid && req.io && !req.write; // RL12

  // Odd parity: total ones including the parity bit is odd
  assign parity_low_byte  = ~(^wdata_lo); // RL17
  assign parity_high_byte = ~(^wdata_hi); // RL17
endmodule // mbc_core

//--- common/mbc_pkg.sv
// How it works
// RL1 - Boot ROM select low for F0000-FFFFF
// RL2 - Config bit picks DRAM or SRAM pins
// RL3 - DRAM mode drives ten-bit multiplexed address
// RL4 - SRAM select low for low range
// RL5 - Separate low/high byte SRAM write strobes
// RL6 - SRAM chip selects for 9xxxx, 8xxxx
// RL7 - Four bank row strobes select bytes
// RL8 - One shared column strobe
// RL9 - One shared write enable on writes
// RL10 - Refresh flag from programmable refresh timer
// RL11 - Enable I/O channel transceiver
// RL12 - I/O direction high inward, rests low
// RL13 - CPU buffer disabled during DMA
// RL14 - CPU buffer gated by data enable
// RL15 - CPU buffer direction high toward device
// RL16 - Data enable for mem, I/O, INTA
// RL17 - Parity bit makes byte odd
package mbc_pkg;
  localparam logic [3:0]  ROM_SEG      = 4'hF;
  localparam logic [3:0]  SRAM_SEG9    = 4'h9;
  localparam logic [3:0]  SRAM_SEG8    = 4'h8;
  localparam int          CLK_NS       = 10;
  localparam int          REF_MIN_NS   = 838;
  localparam int          REF_MAX_NS   = 214000;
  localparam int          REF_MIN_CYC  = (REF_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int          REF_MAX_CYC  = REF_MAX_NS / CLK_NS;
  localparam int          REF_PULSE    = 4;
  localparam int          ROW_COL_GAP  = 2;
  localparam int          CAS_LEN      = 3;

  typedef enum logic [2:0] {
    MBC_IDLE, MBC_ROW, MBC_COL, MBC_DONE, MBC_REF
  } mbc_state_e;

  // One processor or DMA bus request (memory, I/O or INTA)
  typedef struct packed {
    logic        mem;
    logic        io;
    logic        inta;
    logic        write;
    logic        dma;
    logic        t2;
    logic        byte_lo;
    logic        byte_hi;
    logic [19:0] addr;
  } mbc_req_s;
endpackage

//--- verif/mbc_chk.sv
`timescale 1ns/100ps
module mbc_chk (
  input wire logic              clock,
  input wire logic              reset,
  input wire mbc_pkg::mbc_req_s req,
  input wire logic              req_valid,
  input wire logic              hold_ack,
  input wire logic [7:0]        wdata_lo,
  input wire logic              done,
  input wire logic              col_strobe_n,
  input wire logic              dram_write_n,
  input wire logic              refresh_active,
  input wire logic [3:0]        bank_row_strobe_n,
  input wire logic              cpu_xfer_active_oe_n,
  input wire logic              cpu_buf_enable_n,
  input wire logic              cpu_buf_inward,
  input wire logic              io_xcvr_inward,
  input wire logic              parity_low_byte
);
  import mbc_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // Column phase is three cycles, then done follows
  property p_col; $fell(col_strobe_n) |-> !col_strobe_n[*3] ##1 done; endproperty
  a_col: assert property (p_col) else $error("column phase length wrong");
  property p_we; !dram_write_n |-> !(&bank_row_strobe_n) && !refresh_active; endproperty
  a_we: assert property (p_we) else $error("write enable outside an access");
  property p_ref; refresh_active |-> bank_row_strobe_n == 4'h0; endproperty
  a_ref: assert property (p_ref) else $error("refresh without all row strobes");
  property p_ref_len; $rose(refresh_active) |-> refresh_active[*4] ##1 !refresh_active; endproperty
  a_ref_len: assert property (p_ref_len) else $error("refresh length wrong");
  property p_io_rest; !req_valid |-> !io_xcvr_inward; endproperty
  a_io_rest: assert property (p_io_rest) else $error("io direction not resting low");
  property p_dma; req_valid && (req.dma || req.t2) |-> cpu_buf_enable_n; endproperty
  a_dma: assert property (p_dma) else $error("cpu buffer enabled in dma or t2");
  property p_dir; req_valid && !req.dma |-> cpu_buf_inward == req.write; endproperty
  a_dir: assert property (p_dir) else $error("cpu buffer direction wrong");
  property p_hold; hold_ack |-> cpu_xfer_active_oe_n; endproperty
  a_hold: assert property (p_hold) else $error("data enable driven in hold");
  property p_par; ^{wdata_lo, parity_low_byte}; endproperty
  a_par: assert property (p_par) else $error("low parity not odd");
  c_done: cover property (done);
  c_ref: cover property (refresh_active);
  c_wr: cover property (!dram_write_n);
endmodule // mbc_chk
bind mbc_core mbc_chk u_mbc_chk (.*);

//--- verif/mbc_dram_model.sv
`timescale 1ns/100ps
module mbc_dram_model (
  input wire logic       clock,
  input wire logic [9:0] addr,
  input wire logic [3:0] row_n,
  input wire logic       col_n,
  input wire logic       we_n,
  output logic [9:0]     row_reg,
  output logic [9:0]     col_reg,
  output logic           wr_reg
);
  logic r_q = 1'b1;
  logic c_q = 1'b1;
  // Sampled on the clock so strobe and write enable edges never race
  always @(posedge clock) begin
    if (r_q && !(&row_n)) row_reg <= addr;
    if (c_q && !col_n) begin
      col_reg <= addr;
      wr_reg <= !we_n;
    end
    r_q <= &row_n;
    c_q <= col_n;
  end
endmodule // mbc_dram_model

//--- verif/memory_and_buffer_control_tb.sv
`timescale 1ns/100ps
module memory_and_buffer_control_tb;
  import mbc_pkg::*;
  logic clock = 0, reset = 1, enable = 1, req_valid = 0, sram_mode = 0, hold_ack = 0;
  mbc_req_s req = '0;
  logic [7:0] wdata_lo = 8'h00, wdata_hi = 8'h00;
  logic done, boot_rom_sel_n, mux_addr_bit9, mux_addr_bit8, mux_addr7_or_low_sram_sel_n, mux_addr6_or_sram_wr_lo_n;
  logic mux_addr5_or_sram_wr_hi_n, mux_addr4_or_sram_seg9_sel_n, mux_addr3_or_sram_seg8_sel_n, col_strobe_n;
  logic dram_write_n, refresh_active, cpu_xfer_active, cpu_xfer_active_oe_n, io_xcvr_enable, io_xcvr_inward;
  logic cpu_buf_enable_n, cpu_buf_inward, parity_low_byte, parity_high_byte, wr_reg, rom_seen;
  logic [2:0] mux_addr_low;
  logic [3:0] bank_row_strobe_n, rs;
  logic [4:0] low_seen;
  logic [9:0] row_reg, col_reg;
  int failures = 0, checks_done = 0, cyc = 0;
  wire logic [4:0] pins = {mux_addr7_or_low_sram_sel_n, mux_addr6_or_sram_wr_lo_n, mux_addr5_or_sram_wr_hi_n,
                           mux_addr4_or_sram_seg9_sel_n, mux_addr3_or_sram_seg8_sel_n};
  mbc_core #(.REF_PERIOD(30)) u_mbc_core (.*);
  mbc_dram_model u_mbc_dram_model (.clock(clock), .addr({mux_addr_bit9, mux_addr_bit8, pins, mux_addr_low}),
    .row_n(bank_row_strobe_n), .col_n(col_strobe_n), .we_n(dram_write_n), .row_reg(row_reg), .col_reg(col_reg),
    .wr_reg(wr_reg));
  initial forever #5 clock = ~clock;
  // Hang guard, far above the longest sequence
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      end_sim();
    end
  end
  task automatic end_sim();
    if (failures == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  // One whole access; records lows seen, since a refresh may delay the start
  task automatic acc(input logic [19:0] a, input logic w, input logic lo, input logic hi);
    int n = 0;
    rom_seen = 0;
    low_seen = '0;
    rs = 4'hF;
    req = '{mem: 1'b1, write: w, byte_lo: lo, byte_hi: hi, addr: a, default: 1'b0};
    req_valid = 1;
    do begin
      @(posedge clock);
      #1 n++;
      rom_seen |= !boot_rom_sel_n;
      low_seen |= ~pins;
      if (!col_strobe_n) rs = bank_row_strobe_n;
    end while (done !== 1'b1 && n < 60);
    req_valid = 0;
    chk("done", {31'h0, done}, 32'h1);
    @(posedge clock);
    #1;
  endtask
  // Clock enable low: a pending request must not start
  task automatic en_t();
    enable = 0;
    req = '{mem: 1'b1, byte_lo: 1'b1, addr: 20'hF0000, default: 1'b0};
    req_valid = 1;
    repeat (3) @(posedge clock);
    #1 chk("frz_ras", {28'h0, bank_row_strobe_n}, 32'hF);
    chk("frz_rom", {31'h0, boot_rom_sel_n}, 32'h1);
    req_valid = 0;
    @(posedge clock);
    #1 enable = 1;
  endtask
  task automatic dram_t();
    acc(20'hF0000, 1, 1, 0);
    chk("rom", {31'h0, rom_seen}, 32'h1);
    chk("ras", {28'h0, rs}, 32'hB);
    chk("row", {22'h0, row_reg}, 32'h3C0);
    chk("col", {22'h0, col_reg}, 32'h0);
    chk("wr", {31'h0, wr_reg}, 32'h1);
    acc(20'hEFFFF, 0, 0, 1);
    chk("rom", {31'h0, rom_seen}, 32'h0);
    chk("ras", {28'h0, rs}, 32'h7);
    chk("row", {22'h0, row_reg}, 32'h3BF);
    chk("col", {22'h0, col_reg}, 32'h3FF);
    chk("wr", {31'h0, wr_reg}, 32'h0);
  endtask
  task automatic sram_t();
    sram_mode = 1;
    acc(20'h9ABCD, 1, 0, 1);
    chk("sram9", {27'h0, low_seen}, 32'h06);
    acc(20'h80000, 1, 1, 0);
    chk("sram8", {27'h0, low_seen}, 32'h09);
    acc(20'h7FFFF, 0, 1, 1);
    chk("sramlo", {27'h0, low_seen}, 32'h10);
    sram_mode = 0;
  endtask
  task automatic buf_t();
    req = '{io: 1'b1, dma: 1'b1, write: 1'b1, default: 1'b0};
    req_valid = 1;
    hold_ack = 1;
    wdata_lo = 8'h07;
    wdata_hi = 8'h01;
    #10 chk("pbuf", {31'h0, cpu_buf_enable_n}, 32'h1);
    chk("den_oe", {31'h0, cpu_xfer_active_oe_n}, 32'h1);
    chk("par", {31'h0, parity_low_byte}, 32'h0);
    chk("parh", {31'h0, parity_high_byte}, 32'h0);
    chk("ioen", {31'h0, io_xcvr_enable}, 32'h1);
    req.dma = 0;
    hold_ack = 0;
    wdata_lo = 8'hFF;
    #10 chk("pdir", {31'h0, cpu_buf_inward}, 32'h1);
    chk("par", {31'h0, parity_low_byte}, 32'h1);
    chk("den", {31'h0, cpu_xfer_active}, 32'h1);
    chk("pbuf", {31'h0, cpu_buf_enable_n}, 32'h0);
    req.write = 0;
    req.t2 = 1;
    #10 chk("iodir", {31'h0, io_xcvr_inward}, 32'h1);
    chk("pdir", {31'h0, cpu_buf_inward}, 32'h0);
    chk("pbuf", {31'h0, cpu_buf_enable_n}, 32'h1);
    req_valid = 0;
    #10 chk("iodir", {31'h0, io_xcvr_inward}, 32'h0);
    chk("ioen", {31'h0, io_xcvr_enable}, 32'h0);
  endtask
  initial begin
    repeat (4) @(posedge clock);
    #1 reset = 0;
    dram_t();
    en_t();
    sram_t();
    buf_t();
    end_sim();
  end
endmodule // memory_and_buffer_control_tb
